//--- hdl/dttd_pkg.sv
// Purpose: shared constants and types of the dual timer unit
// Assumes: 8-bit registers, one per aligned 32-bit Wishbone word
// Notes:   offsets are byte addresses
package dttd_pkg;

  // ********************************
  // register offsets
  // ********************************
  localparam logic [7:0] OFS_NCTL   = 8'h00; // narrow_timer_control
  localparam logic [7:0] OFS_MODE   = 8'h04; // timer_mode_control
  localparam logic [7:0] OFS_WCTL   = 8'h08; // wide_timer_control
  localparam logic [7:0] OFS_NRLL   = 8'h0c; // narrow_reload_low
  localparam logic [7:0] OFS_NRLH   = 8'h10; // narrow_reload_high
  localparam logic [7:0] OFS_WRLL   = 8'h14; // wide reload low byte
  localparam logic [7:0] OFS_WRLH   = 8'h18; // wide reload high byte
  localparam logic [7:0] OFS_HCAP   = 8'h1c; // high_capture
  localparam logic [7:0] OFS_LCAP   = 8'h20; // low_capture
  localparam logic [7:0] OFS_ISTAT  = 8'h24; // interrupt status
  localparam logic [7:0] OFS_IMASK  = 8'h28; // interrupt mask

  // ********************************
  // field positions
  // ********************************
  localparam int BIT_EN     = 7; // enable in both control regs
  localparam int BIT_TOUT   = 5; // timeout status in both control regs
  localparam int BIT_DEMOD  = 7; // mode reg: 1 = demodulation
  localparam int BIT_LE_HI  = 5; // logic/edge field high bit
  localparam int BIT_LE_LO  = 4;
  localparam int BIT_SUB_HI = 3; // submode field
  localparam int BIT_SUB_LO = 2;
  localparam int BIT_NINIT  = 1; // narrow initial level / rise flag
  localparam int BIT_WINIT  = 0; // wide initial level / fall flag

  // interrupt status bits
  localparam int IRQ_NTO   = 0;
  localparam int IRQ_WTO   = 1;
  localparam int IRQ_RISE  = 2;
  localparam int IRQ_FALL  = 3;
  localparam int IRQ_CAP   = 4;

  // ********************************
  // reset values
  // ********************************
  localparam logic [7:0] RST_CTL  = 8'h00;
  localparam logic [7:0] RST_RELD = 8'hff;

  // ********************************
  // timing: software events take one timer clock
  // ********************************
  localparam int TCLK_NS     = 10;
  localparam int EVT_DELAY_NS = 10;
  localparam int EVT_DELAY_CYC = (EVT_DELAY_NS + TCLK_NS - 1) / TCLK_NS;

  typedef enum logic [1:0] {
    SUB_NORMAL = 2'b00,
    SUB_ALT    = 2'b01,
    SUB_LOW    = 2'b10,
    SUB_HIGH   = 2'b11
  } dttd_sub_t;

  typedef enum logic [1:0] {
    LE_AND  = 2'b00,
    LE_OR   = 2'b01,
    LE_NOR  = 2'b10,
    LE_NAND = 2'b11
  } dttd_logic_t;

  typedef struct packed {
    logic       we;
    logic [7:0] adr;
    logic [7:0] dat;
  } dttd_wr_t;

endpackage

//--- hdl/dttd_edge.sv
// Purpose: input edge detector with edge selection
// Assumes: input synchronous to clk_in
// Notes:   pulses are one cycle wide
`timescale 1ns/1ns
`default_nettype none
module dttd_edge (
  input  wire logic       clk_in,
  input  wire logic       arst_n_in,
  input  wire logic       sig_in,
  input  wire logic [1:0] sel_in,
  output logic            rise_out,
  output logic            fall_out,
  output logic            hit_out,
  output logic            lvl_out
);
  import dttd_pkg::*;

  logic prev_ff;
  logic nxt_prev;

  always_comb begin
    nxt_prev = sig_in;
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      prev_ff <= 1'b0;
    end else begin
      prev_ff <= nxt_prev;
    end
  end

  // sel: 00 none, 01 rising, 10 falling, 11 both
  always_comb begin
    rise_out = sig_in & ~prev_ff;
    fall_out = ~sig_in & prev_ff;
    hit_out  = (sel_in[0] & rise_out) | (sel_in[1] & fall_out);
    lvl_out  = prev_ff;
  end
endmodule
`default_nettype wire

//--- hdl/dttd_down.sv
// Purpose: reloadable down counter with terminal-count pulse
// Assumes: reload applied on load or on terminal count
// Notes:   zero to all-ones wrap without reload is not a timeout
`timescale 1ns/1ns
`default_nettype none
module dttd_down #(
  parameter int W = 8
) (
  input  wire logic         clk_in,
  input  wire logic         arst_n_in,
  input  wire logic         load_in,
  input  wire logic         run_in,
  input  wire logic         autoload_in,
  input  wire logic [W-1:0] reload_in,
  output logic [W-1:0]      count_out,
  output logic              tc_out
);
  import dttd_pkg::*;

  logic [W-1:0] cnt_ff;
  logic [W-1:0] nxt_cnt;

  always_comb begin
    tc_out  = run_in && !load_in && (cnt_ff == '0) && autoload_in;
    nxt_cnt = cnt_ff;
    if (load_in) begin
      nxt_cnt = reload_in;
    end else if (run_in) begin
      if (tc_out) begin
        nxt_cnt = reload_in;
      end else begin
        nxt_cnt = cnt_ff - {{(W-1){1'b0}}, 1'b1};
      end
    end
    count_out = cnt_ff;
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end
endmodule
`default_nettype wire

//--- hdl/dttd_top.sv
// Purpose: paired narrow/wide timer unit, transmit and pulse measure
// Assumes: classic Wishbone slave, 8-bit data in the low byte
// Notes:   ack one cycle after request; writes act on the next edge
//
// Functional notes
// - waveform mode: wide output takes initial level when wide timer starts
// - wide initial level honoured only in normal or alternating submode; narrow honours it in every submode
// - waveform mode: disabled wide timer holds output at inverse of initial level
// - pulse mode: falling edge sets fall flag; writing one clears it
// - zero to all-ones wrap is never a timeout
// - software-started events act one timer clock after the write
// - pulse mode: narrow timer waits for first selected edge, then counts
// - later selected edge stores complement of count into a capture
// - both edges selected: high capture gets high-time count, low capture low-time count
// - alternating mode: hardware toggles the two enables in turn
// - alternating mode: each terminal count sets that timer's timeout
// - submode: normal, alternating, force low, force high
// - logic/edge field: output combine or measured edge
// - pulse mode: rising edge sets rise flag; writing one clears it
//
// Design decision made here: the Wishbone interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module dttd_top (
  input  wire logic        clk_in,
  input  wire logic        arst_n_in,
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [7:0]  wb_adr_in,
  input  wire logic [3:0]  wb_sel_in,
  input  wire logic [31:0] wb_dat_in,
  output logic [31:0]      wb_dat_out,
  output logic             wb_ack_out,
  input  wire logic        meas_in,
  output logic             wide_timer_output_out,
  output logic             narrow_timer_output_out,
  output logic             combined_output_out,
  output logic             irq_out
);
  import dttd_pkg::*;

  // ********************************
  // register state
  // ********************************
  logic [7:0]  nctl_ff, nxt_nctl;
  logic [7:0]  mode_ff, nxt_mode;
  logic [7:0]  wctl_ff, nxt_wctl;
  logic [7:0]  nrll_ff, nxt_nrll;
  logic [7:0]  nrlh_ff, nxt_nrlh;
  logic [7:0]  wrll_ff, nxt_wrll;
  logic [7:0]  wrlh_ff, nxt_wrlh;
  logic [7:0]  hcap_ff, nxt_hcap;
  logic [7:0]  lcap_ff, nxt_lcap;
  logic [4:0]  ista_ff, nxt_ista;
  logic [4:0]  imsk_ff, nxt_imsk;
  logic        ack_ff, nxt_ack;
  logic [31:0] rdat_ff, nxt_rdat;
  logic        wout_ff, nxt_wout;
  logic        nout_ff, nxt_nout;
  logic        cout_ff, nxt_cout;
  logic        irq_ff, nxt_irq;
  logic        armed_ff, nxt_armed;
  logic        nrun_ff, nxt_nrun;
  logic        wrun_ff, nxt_wrun;
  logic        nphase_ff, nxt_nphase;
  dttd_wr_t    wr_ff, nxt_wr;

  // ********************************
  // decoded control
  // ********************************
  logic        demod;
  logic        nen, wen;
  dttd_sub_t   sub;
  logic [1:0]  lefld;
  logic        ntc, wtc;
  logic [7:0]  ncount;
  logic [15:0] wcount;
  logic        rise, fall, hit, lvl;
  logic        nstart, wstart;
  logic        req, wr_now;

  always_comb begin
    demod = mode_ff[BIT_DEMOD];
    nen   = nctl_ff[BIT_EN];
    wen   = wctl_ff[BIT_EN];
    sub   = dttd_sub_t'(mode_ff[BIT_SUB_HI:BIT_SUB_LO]);
    lefld = mode_ff[BIT_LE_HI:BIT_LE_LO];
    req   = wb_cyc_in && wb_stb_in && !ack_ff;
    // write lands at the acking edge; hardware sees it one edge later
    wr_now = wr_ff.we;
    nstart = nen && !nrun_ff;
    wstart = wen && !wrun_ff && !demod;
  end

  function automatic logic [7:0] hit_reg(input logic [7:0] a, input logic [7:0] o);
    hit_reg = {7'h00, a == o};
  endfunction

  function automatic logic comb_out(input logic [1:0] f, input logic a, input logic b);
    case (f)
      LE_AND:  comb_out = a & b;
      LE_OR:   comb_out = a | b;
      LE_NOR:  comb_out = ~(a | b);
      default: comb_out = ~(a & b);
    endcase
  endfunction

  // ********************************
  // counters and edge detector
  // ********************************
  dttd_edge u_edge (
    .clk_in    (clk_in),
    .arst_n_in (arst_n_in),
    .sig_in    (meas_in),
    .sel_in    (lefld),
    .rise_out  (rise),
    .fall_out  (fall),
    .hit_out   (hit),
    .lvl_out   (lvl)
  );

  // pulse mode turns autoload off, so free-running wrap gives no timeout
  dttd_down #(.W(8)) u_narrow (
    .clk_in      (clk_in),
    .arst_n_in   (arst_n_in),
    .load_in     (nstart || (demod && armed_ff && hit)),
    .run_in      (nen && nrun_ff && (!demod || armed_ff)),
    .autoload_in (!demod),
    .reload_in   (nphase_ff ? nrlh_ff : nrll_ff),
    .count_out   (ncount),
    .tc_out      (ntc)
  );

  dttd_down #(.W(16)) u_wide (
    .clk_in      (clk_in),
    .arst_n_in   (arst_n_in),
    .load_in     (wstart),
    .run_in      (wen && wrun_ff && !demod),
    .autoload_in (1'b1),
    .reload_in   ({wrlh_ff, wrll_ff}),
    .count_out   (wcount),
    .tc_out      (wtc)
  );

  // ********************************
  // next-state logic
  // ********************************
  always_comb begin
    nxt_nctl   = nctl_ff;
    nxt_mode   = mode_ff;
    nxt_wctl   = wctl_ff;
    nxt_nrll   = nrll_ff;
    nxt_nrlh   = nrlh_ff;
    nxt_wrll   = wrll_ff;
    nxt_wrlh   = wrlh_ff;
    nxt_hcap   = hcap_ff;
    nxt_lcap   = lcap_ff;
    nxt_ista   = ista_ff;
    nxt_imsk   = imsk_ff;
    nxt_armed  = armed_ff;
    nxt_nphase = nphase_ff;
    nxt_nrun   = nen;
    nxt_wrun   = wen && !demod;
    nxt_wout   = wout_ff;
    nxt_nout   = nout_ff;
    nxt_ack    = req;
    nxt_rdat   = rdat_ff;
    nxt_wr     = '0;

    // bus: capture request, apply write one edge later
    if (req) begin
      nxt_wr.we  = wb_we_in && wb_sel_in[0];
      nxt_wr.adr = wb_adr_in;
      nxt_wr.dat = wb_dat_in[7:0];
      unique case (wb_adr_in)
        OFS_NCTL:  nxt_rdat = {24'h0, nctl_ff};
        OFS_MODE:  nxt_rdat = {24'h0, mode_ff};
        OFS_WCTL:  nxt_rdat = {24'h0, wctl_ff};
        OFS_NRLL:  nxt_rdat = {24'h0, nrll_ff};
        OFS_NRLH:  nxt_rdat = {24'h0, nrlh_ff};
        OFS_WRLL:  nxt_rdat = {24'h0, wrll_ff};
        OFS_WRLH:  nxt_rdat = {24'h0, wrlh_ff};
        OFS_HCAP:  nxt_rdat = {24'h0, hcap_ff};
        OFS_LCAP:  nxt_rdat = {24'h0, lcap_ff};
        OFS_ISTAT: nxt_rdat = {27'h0, ista_ff};
        OFS_IMASK: nxt_rdat = {27'h0, imsk_ff};
        default:   nxt_rdat = 32'h0;
      endcase
    end

    // software writes; status bits are write-one-to-clear
    if (wr_now) begin
      if (|hit_reg(wr_ff.adr, OFS_NCTL)) begin
        nxt_nctl = {wr_ff.dat[7:6], nctl_ff[BIT_TOUT] & ~wr_ff.dat[BIT_TOUT], wr_ff.dat[4:0]};
      end
      if (|hit_reg(wr_ff.adr, OFS_WCTL)) begin
        nxt_wctl = {wr_ff.dat[7:6], wctl_ff[BIT_TOUT] & ~wr_ff.dat[BIT_TOUT], wr_ff.dat[4:0]};
      end
      if (|hit_reg(wr_ff.adr, OFS_MODE)) begin
        if (demod) begin
          nxt_mode = {wr_ff.dat[7:2], mode_ff[1:0] & ~wr_ff.dat[1:0]};
        end else begin
          nxt_mode = wr_ff.dat;
        end
      end
      if (|hit_reg(wr_ff.adr, OFS_NRLL))  nxt_nrll = wr_ff.dat;
      if (|hit_reg(wr_ff.adr, OFS_NRLH))  nxt_nrlh = wr_ff.dat;
      if (|hit_reg(wr_ff.adr, OFS_WRLL))  nxt_wrll = wr_ff.dat;
      if (|hit_reg(wr_ff.adr, OFS_WRLH))  nxt_wrlh = wr_ff.dat;
      if (|hit_reg(wr_ff.adr, OFS_ISTAT)) nxt_ista = ista_ff & ~wr_ff.dat[4:0];
      if (|hit_reg(wr_ff.adr, OFS_IMASK)) nxt_imsk = wr_ff.dat[4:0];
    end

    if (!nen) begin
      nxt_armed  = 1'b0;
      nxt_nphase = 1'b0;
    end

    if (!demod) begin
      // transmit: narrow alternates low/high reload halves
      if (nstart) begin
        nxt_nout   = mode_ff[BIT_NINIT];
        nxt_nphase = 1'b0;
      end else if (!nen) begin
        nxt_nout = ~mode_ff[BIT_NINIT];
      end else if (ntc) begin
        nxt_nout   = ~nout_ff;
        nxt_nphase = ~nphase_ff;
      end
      // hardware event set wins over software clear
      if (ntc) begin
        nxt_nctl[BIT_TOUT] = 1'b1;
        nxt_ista[IRQ_NTO]  = 1'b1;
      end
      if (wtc) begin
        nxt_wctl[BIT_TOUT] = 1'b1;
        nxt_ista[IRQ_WTO]  = 1'b1;
      end
      if (sub == SUB_ALT) begin
        // one timer counts at a time; each terminal count hands over
        if (ntc) begin
          nxt_nctl[BIT_EN] = 1'b0;
          nxt_wctl[BIT_EN] = 1'b1;
        end else if (wtc) begin
          nxt_wctl[BIT_EN] = 1'b0;
          nxt_nctl[BIT_EN] = 1'b1;
        end
      end
      // wide output: forced submodes ignore the initial bit
      unique case (sub)
        SUB_LOW:  nxt_wout = 1'b0;
        SUB_HIGH: nxt_wout = 1'b1;
        default: begin
          if (wstart) begin
            nxt_wout = mode_ff[BIT_WINIT];
          end else if (!wen) begin
            nxt_wout = ~mode_ff[BIT_WINIT];
          end else if (wtc) begin
            nxt_wout = ~wout_ff;
          end
        end
      endcase
    end else begin
      // pulse measure: edge flags, arm on first edge, capture later
      if (rise) nxt_mode[BIT_NINIT] = 1'b1;
      if (fall) nxt_mode[BIT_WINIT] = 1'b1;
      if (rise) nxt_ista[IRQ_RISE] = 1'b1;
      if (fall) nxt_ista[IRQ_FALL] = 1'b1;
      if (nen && nrun_ff && hit) begin
        if (!armed_ff) begin
          nxt_armed = 1'b1;
        end else begin
          // level before the edge names the period that just ended
          if (lvl) nxt_hcap = ~ncount;
          else     nxt_lcap = ~ncount;
          nxt_ista[IRQ_CAP] = 1'b1;
        end
      end
    end

    nxt_cout = comb_out(lefld, nxt_nout, nxt_wout);
    nxt_irq  = |(nxt_ista & nxt_imsk);
  end

  // ********************************
  // registers
  // ********************************
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      nctl_ff   <= RST_CTL;
      mode_ff   <= RST_CTL;
      wctl_ff   <= RST_CTL;
      nrll_ff   <= RST_RELD;
      nrlh_ff   <= RST_RELD;
      wrll_ff   <= RST_RELD;
      wrlh_ff   <= RST_RELD;
      hcap_ff   <= 8'h00;
      lcap_ff   <= 8'h00;
      ista_ff   <= 5'h00;
      imsk_ff   <= 5'h00;
      ack_ff    <= 1'b0;
      rdat_ff   <= 32'h0;
      wout_ff   <= 1'b1;
      nout_ff   <= 1'b1;
      cout_ff   <= 1'b1;
      irq_ff    <= 1'b0;
      armed_ff  <= 1'b0;
      nrun_ff   <= 1'b0;
      wrun_ff   <= 1'b0;
      nphase_ff <= 1'b0;
      wr_ff     <= '0;
    end else begin
      nctl_ff   <= nxt_nctl;
      mode_ff   <= nxt_mode;
      wctl_ff   <= nxt_wctl;
      nrll_ff   <= nxt_nrll;
      nrlh_ff   <= nxt_nrlh;
      wrll_ff   <= nxt_wrll;
      wrlh_ff   <= nxt_wrlh;
      hcap_ff   <= nxt_hcap;
      lcap_ff   <= nxt_lcap;
      ista_ff   <= nxt_ista;
      imsk_ff   <= nxt_imsk;
      ack_ff    <= nxt_ack;
      rdat_ff   <= nxt_rdat;
      wout_ff   <= nxt_wout;
      nout_ff   <= nxt_nout;
      cout_ff   <= nxt_cout;
      irq_ff    <= nxt_irq;
      armed_ff  <= nxt_armed;
      nrun_ff   <= nxt_nrun;
      wrun_ff   <= nxt_wrun;
      nphase_ff <= nxt_nphase;
      wr_ff     <= nxt_wr;
    end
  end

  always_comb begin
    wb_dat_out              = rdat_ff;
    wb_ack_out              = ack_ff;
    wide_timer_output_out   = wout_ff;
    narrow_timer_output_out = nout_ff;
    combined_output_out     = cout_ff;
    irq_out                 = irq_ff;
  end
endmodule
`default_nettype wire

//--- dv/dttd_props.sv
// Purpose: port-level checks of the dual timer unit
// Assumes: classic Wishbone master; a write is seen at its ack edge
// Notes:   software state is shadowed from observed writes
`timescale 1ns/1ns
`default_nettype none
module dttd_props
  import dttd_pkg::*;
(
  input wire logic        clk_in,
  input wire logic        arst_n_in,
  input wire logic        wb_cyc_in,
  input wire logic        wb_stb_in,
  input wire logic        wb_we_in,
  input wire logic [7:0]  wb_adr_in,
  input wire logic [3:0]  wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  input wire logic [31:0] wb_dat_out,
  input wire logic        wb_ack_out,
  input wire logic        meas_in,
  input wire logic        wide_timer_output_out,
  input wire logic        narrow_timer_output_out,
  input wire logic        combined_output_out,
  input wire logic        irq_out
);
  // ********************************
  // shadow of software state
  // ********************************
  logic [7:0] mode_ff, nxt_mode;
  logic       wen_ff, nxt_wen, pw_ff, nxt_pw, pn_ff, nxt_pn;
  logic [2:0] quiet_ff, nxt_quiet;
  logic [1:0] stab_ff, nxt_stab, sub;
  logic       wr, w, n, tx, norm, exp_comb;
  assign wr   = wb_cyc_in && wb_stb_in && wb_we_in && wb_ack_out && wb_sel_in[0];
  assign w    = wide_timer_output_out;
  assign n    = narrow_timer_output_out;
  assign sub  = mode_ff[BIT_SUB_HI:BIT_SUB_LO];
  assign norm = !mode_ff[BIT_DEMOD] && sub == SUB_NORMAL;
  // settle time after any write, so latency choices never matter
  assign tx   = !mode_ff[BIT_DEMOD] && quiet_ff[2];
  always_comb begin
    nxt_mode  = mode_ff;
    nxt_wen   = wen_ff;
    nxt_pw    = w;
    nxt_pn    = n;
    nxt_quiet = quiet_ff[2] ? quiet_ff : quiet_ff + 3'h1;
    nxt_stab  = (w == pw_ff && n == pn_ff) ? (stab_ff[1] ? stab_ff : stab_ff + 2'h1) : 2'h0;
    if (wr) nxt_quiet = 3'h0;
    if (wr && wb_adr_in == OFS_MODE) nxt_mode = wb_dat_in[7:0];
    if (wr && wb_adr_in == OFS_WCTL) nxt_wen = wb_dat_in[BIT_EN];
    case (mode_ff[BIT_LE_HI:BIT_LE_LO])
      LE_AND:  exp_comb = w & n;
      LE_OR:   exp_comb = w | n;
      LE_NOR:  exp_comb = !(w | n);
      default: exp_comb = !(w & n);
    endcase
  end
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      mode_ff  <= 8'h00;
      wen_ff   <= 1'b0;
      pw_ff    <= 1'b1;
      pn_ff    <= 1'b1;
      quiet_ff <= 3'h0;
      stab_ff  <= 2'h0;
    end else begin
      mode_ff  <= nxt_mode;
      wen_ff   <= nxt_wen;
      pw_ff    <= nxt_pw;
      pn_ff    <= nxt_pn;
      quiet_ff <= nxt_quiet;
      stab_ff  <= nxt_stab;
    end
  end
  // ********************************
  // properties
  // ********************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  sequence wctl_s(logic v);
    wr && wb_adr_in == OFS_WCTL && wb_dat_in[BIT_EN] == v && wen_ff != v && norm;
  endsequence
  sequence level_s(logic v);
    ##[1:4] (w == v);
  endsequence
  AST_WIDE_START: assert property (wctl_s(1'b1) |-> level_s(mode_ff[BIT_WINIT]))
    else $error("wide output missed its initial level");
  AST_WIDE_STOP: assert property (wctl_s(1'b0) |-> level_s(!mode_ff[BIT_WINIT]))
    else $error("stopping the wide timer took too long");
  AST_IDLE_INV: assert property (tx && sub == SUB_NORMAL && !wen_ff |-> w == !mode_ff[0])
    else $error("idle wide output not inverse of initial level");
  AST_FORCE_LOW: assert property (tx && sub == SUB_LOW |-> !w)
    else $error("forced low submode not low");
  AST_FORCE_HIGH: assert property (tx && sub == SUB_HIGH |-> w)
    else $error("forced high submode not high");
  AST_COMBINE: assert property (tx && stab_ff[1] |-> combined_output_out == exp_comb)
    else $error("combined output wrong for logic field");
  AST_ACK_ONE: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("ack longer than one cycle");
  AST_ACK_NEXT: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
    else $error("ack not one cycle after request");
  AST_UNMAPPED: assert property (wb_cyc_in && !wb_we_in && wb_ack_out && wb_adr_in > OFS_IMASK
    |-> wb_dat_out == 32'h0) else $error("unmapped read not zero");
endmodule
`default_nettype wire

//--- dv/dttd_meas_model.sv
// Purpose: far-side source of the measured input
// Assumes: input is synchronous to clk_in, low when idle
// Notes:   each pulse is hi cycles high then lo cycles low
`timescale 1ns/1ns
`default_nettype none
module dttd_meas_model (
  input  wire logic       clk_in,
  input  wire logic       arst_n_in,
  input  wire logic       go_in,
  input  wire logic [7:0] hi_in,
  input  wire logic [7:0] lo_in,
  input  wire logic [1:0] n_in,
  output logic            meas_out,
  output logic            busy_out
);
  logic [7:0] cnt;
  logic [1:0] left;
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      meas_out <= 1'b0;
      busy_out <= 1'b0;
      cnt      <= 8'h00;
      left     <= 2'h0;
    end else if (go_in && !busy_out) begin
      busy_out <= 1'b1;
      meas_out <= 1'b1;
      cnt      <= hi_in;
      left     <= n_in;
    end else if (busy_out) begin
      if (cnt > 8'h01) cnt <= cnt - 8'h01;
      else if (meas_out) begin
        meas_out <= 1'b0;
        cnt      <= lo_in;
      end else if (left > 2'h1) begin
        left     <= left - 2'h1;
        meas_out <= 1'b1;
        cnt      <= hi_in;
      end else busy_out <= 1'b0;
    end
  end
endmodule
`default_nettype wire

//--- dv/dttd_tb_top.sv
// Purpose: self-checking bench of the dual timer unit
// Assumes: partner model drives the measured input
// Notes:   expected read values are noted in a queue and checked at ack
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin fails++; \
  $display("wrong value at %0t: %h vs %h", $time, (a), (b)); end end
module dttd_tb_top;
  import dttd_pkg::*;
  logic        clk_in, arst_n_in, wb_cyc_in, wb_stb_in, wb_we_in, wb_ack_out, irq_out;
  logic        meas_in, wide_timer_output_out, narrow_timer_output_out, combined_output_out;
  logic        go, busy, s0, s1;
  logic [7:0]  wb_adr_in, m, q, hi, lo;
  logic [3:0]  wb_sel_in;
  logic [31:0] wb_dat_in, wb_dat_out, seed;
  logic [15:0] expq[$];
  int          checks_done, fails, cycles;
  dttd_top dttd_top_inst (.clk_in, .arst_n_in, .wb_cyc_in, .wb_stb_in, .wb_we_in, .wb_adr_in,
    .wb_sel_in, .wb_dat_in, .wb_dat_out, .wb_ack_out, .meas_in, .wide_timer_output_out,
    .narrow_timer_output_out, .combined_output_out, .irq_out);
  dttd_meas_model dttd_meas_model_inst (.clk_in, .arst_n_in, .go_in(go), .hi_in(hi),
    .lo_in(lo), .n_in(2'h2), .meas_out(meas_in), .busy_out(busy));
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = !clk_in;
  end
  // ********************************
  // bus tasks and result watcher
  // ********************************
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    wb_cyc_in <= 1'b1;
    wb_stb_in <= 1'b1;
    wb_we_in  <= w;
    wb_adr_in <= a;
    wb_dat_in <= {24'h0, d};
    do @(posedge clk_in); while (wb_ack_out !== 1'b1);
    q = wb_dat_out[7:0];
    wb_cyc_in <= 1'b0;
    wb_stb_in <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] k);
    expq.push_back({k, e});
    bus(1'b0, a, 8'h00);
  endtask
  task automatic wait_cyc(input int c);
    repeat (c) @(posedge clk_in);
  endtask
  always @(negedge clk_in) begin : watch
    logic [15:0] e;
    if (wb_ack_out === 1'b1 && wb_we_in === 1'b0) begin
      e = expq.pop_front();
      `CHK(wb_dat_out[7:0] & e[15:8], e[7:0] & e[15:8])
    end
  end
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // hang guard well above the fewer than two thousand cycles the tests need
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      wrap_up();
    end
  end
  // ********************************
  // main sequence
  // ********************************
  initial begin
    seed = 32'h886467a5;
    {wb_cyc_in, wb_stb_in, wb_we_in, go, arst_n_in} = 5'h0;
    {wb_adr_in, hi, lo} = 24'h0;
    wb_sel_in = 4'h1;
    wb_dat_in = 32'h0;
    wait_cyc(5);
    arst_n_in <= 1'b1;
    rd(OFS_NCTL, RST_CTL, 8'hff);
    rd(OFS_NRLL, RST_RELD, 8'hff);
    rd(OFS_NRLH, RST_RELD, 8'hff);
    rd(8'h3c, 8'h00, 8'hff);
    `CHK(wide_timer_output_out, 1'b1)
    $display("reset test done");
    for (int i = 0; i < 12; i++) begin
      m = 8'($random(seed));
      m = {2'b00, m[5:4], 2'(i), m[1:0]};
      wr(OFS_MODE, m);
      wait_cyc(5);
      `CHK(wide_timer_output_out, m[3] ? m[2] : !m[0])
    end
    $display("submode test done");
    wr(OFS_WRLL, 8'hff);
    wr(OFS_WRLH, 8'hff);
    wr(OFS_MODE, 8'h01);
    wait_cyc(4);
    `CHK(wide_timer_output_out, 1'b0)
    wr(OFS_WCTL, 8'h80);
    wait_cyc(3);
    `CHK(wide_timer_output_out, 1'b1)
    wr(OFS_WCTL, 8'h00);
    wait_cyc(3);
    `CHK(wide_timer_output_out, 1'b0)
    $display("start stop test done");
    wr(OFS_NRLL, 8'h03);
    wr(OFS_NRLH, 8'h03);
    wr(OFS_WRLL, 8'h04);
    wr(OFS_WRLH, 8'h00);
    wr(OFS_IMASK, 8'h00);
    wr(OFS_MODE, 8'h04);
    wr(OFS_NCTL, 8'h80);
    wait_cyc(200);
    rd(OFS_NCTL, 8'h20, 8'h20);
    rd(OFS_WCTL, 8'h20, 8'h20);
    rd(OFS_ISTAT, 8'h03, 8'h03);
    {s0, s1} = 2'b00;
    repeat (10) begin
      rd(OFS_NCTL, 8'h20, 8'h7f);
      if (q[BIT_EN]) s1 = 1'b1;
      else s0 = 1'b1;
    end
    `CHK({s1, s0}, 2'b11)
    `CHK(irq_out, 1'b0)
    wr(OFS_IMASK, 8'h03);
    wait_cyc(3);
    `CHK(irq_out, 1'b1)
    wr(OFS_MODE, 8'h00);
    wr(OFS_NCTL, 8'h00);
    wr(OFS_WCTL, 8'h00);
    wr(OFS_NCTL, 8'h20);
    wr(OFS_WCTL, 8'h20);
    wr(OFS_ISTAT, 8'h03);
    wait_cyc(3);
    rd(OFS_ISTAT, 8'h00, 8'h03);
    rd(OFS_NCTL, 8'h00, 8'ha0);
    `CHK(irq_out, 1'b0)
    $display("alternating test done");
    wr(OFS_NRLL, 8'hff);
    wr(OFS_NRLH, 8'hff);
    wr(OFS_MODE, 8'hb0);
    wr(OFS_ISTAT, 8'h1f);
    wr(OFS_NCTL, 8'h80);
    hi = 8'd20 + (8'($random(seed)) & 8'h1f);
    lo = 8'd60 + (8'($random(seed)) & 8'h1f);
    wait_cyc(100);
    go <= 1'b1;
    @(posedge clk_in);
    go <= 1'b0;
    wait_cyc(2);
    while (busy) @(posedge clk_in);
    rd(OFS_MODE, 8'h03, 8'h03);
    rd(OFS_HCAP, 8'h00, 8'h80);
    `CHK(q + 8'd3 >= hi && q <= hi + 8'd3, 1'b1)
    rd(OFS_LCAP, 8'h00, 8'h80);
    `CHK(q + 8'd3 >= lo && q <= lo + 8'd3, 1'b1)
    wr(OFS_MODE, 8'hb1);
    rd(OFS_MODE, 8'h02, 8'h03);
    wr(OFS_MODE, 8'hb2);
    rd(OFS_MODE, 8'h00, 8'h03);
    wait_cyc(600);
    rd(OFS_NCTL, 8'h80, 8'ha0);
    // rising edges only: low capture spans a whole period
    wr(OFS_MODE, 8'h93);
    go <= 1'b1;
    @(posedge clk_in);
    go <= 1'b0;
    wait_cyc(2);
    while (busy) @(posedge clk_in);
    rd(OFS_LCAP, 8'h00, 8'h00);
    `CHK(q + 8'd3 >= hi + lo && q <= hi + lo + 8'd3, 1'b1)
    // flags still follow both edges; clear them before leaving
    wr(OFS_MODE, 8'h93);
    wr(OFS_NCTL, 8'h00);
    wr(OFS_MODE, 8'h00);
    $display("pulse measure test done");
    wait_cyc(5);
    wrap_up();
  end
endmodule
bind dttd_top dttd_props dttd_props_inst (.clk_in, .arst_n_in, .wb_cyc_in, .wb_stb_in,
  .wb_we_in, .wb_adr_in, .wb_sel_in, .wb_dat_in, .wb_dat_out, .wb_ack_out, .meas_in,
  .wide_timer_output_out, .narrow_timer_output_out, .combined_output_out, .irq_out);
`default_nettype wire
